// ### hdl/apc_pkg.sv
// Purpose: constants and carrier types for the antenna / preamble configuration block
// Assumes: byte-wide control port access, register addresses as printed
// Notes: reset values are zero because none is given for these registers
package apc_pkg;
	// ---------------------------------------------------------------
	// register addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] APC_ADDR_ANT_CTRL = 8'h14;
	localparam logic [7:0] APC_ADDR_PREAMBLE = 8'h18;
	localparam logic [7:0] APC_ADDR_SCRAMBLER = 8'h1C;
	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int APC_BIT_COVER_SEL = 7;
	localparam int APC_BIT_RSVD = 6;
	localparam int APC_BIT_ADC_ADJ = 5;
	localparam int APC_BIT_DELAY_SYNC = 4;
	localparam int APC_BIT_MULTIPATH = 3;
	localparam int APC_BIT_DIVERSITY = 2;
	localparam int APC_BIT_RXCLK_FREE = 7;
	localparam logic [7:0] APC_RST_ANT_CTRL = 8'h00;
	localparam logic [7:0] APC_RST_PREAMBLE = 8'h00;
	localparam logic [7:0] APC_RST_SCRAMBLER = 8'h00;
	localparam logic [7:0] APC_PA_RAMP_SYMBOLS = 8'h02;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int APC_CLK_MHZ = 100;
	localparam int APC_DWELL_US = 16;
	localparam int APC_DWELL_CYCLES = APC_DWELL_US * APC_CLK_MHZ;
	// antenna mode encodings
	typedef enum logic [1:0]
	{
		APC_MODE_LAST = 2'b00,
		APC_MODE_ILLEGAL = 2'b01,
		APC_MODE_B = 2'b10,
		APC_MODE_A = 2'b11
	} apc_ant_mode_t;
	// decoded configuration carried to the modem core
	typedef struct packed
	{
		logic cover_code_sel;
		logic adc_timing_adjust;
		logic delayed_bit_sync;
		logic multipath_select;
		logic diversity_on;
		logic rx_clock_free;
	} apc_cfg_t;
endpackage : apc_pkg

// ### hdl/apc_dwell_timer.sv
// Purpose: enable-gated antenna dwell timer producing one-cycle tick pulses
// Assumes: single clock, enable held during acquisition
// Notes: restarts at zero whenever enable drops
`timescale 1ns/1ps
module apc_dwell_timer
	import apc_pkg::*;
#(
	parameter int CYCLES = APC_DWELL_CYCLES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic enable_i,
	output logic tick_o
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic tick_d;
	logic tick_q;
	// count to the dwell length, pulse at wrap
	always_comb
	begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (!enable_i)
		begin
			cnt_d = 16'h0000;
		end
		else if (cnt_q == 16'(CYCLES - 1))
		begin
			cnt_d = 16'h0000;
			tick_d = 1'b1;
		end
		else
		begin
			cnt_d = cnt_q + 16'h0001;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d & enable_i;
		end
	end
	assign tick_o = tick_q;
endmodule : apc_dwell_timer

// ### hdl/apc_antenna_preamble_config.sv
// Purpose: antenna control, preamble length and receive clock option registers
// Assumes: byte control port already decoded to a write strobe and address on clk_i
// Notes: antenna select pin is a registered output; pin-side inputs are synchronised
// Summary of operation
// - bit 7 of antenna control chooses signal fields or cover code meaning.
// - bit 5 enables converter timing adjust, active only after receive enable drops.
// - bit 4 delays bit sync accumulation; zero means normal accumulation.
// - bit 3 chooses antenna by multipath quality; zero means normal selection.
// - diversity off receives on one antenna chosen by the mode field.
// - diversity on alternates antennas every 16 us, starting on mode antenna.
// - mode field sets start antenna for clear-channel check and transmit; drives pin.
// - transmit always uses the clear-channel check antenna.
// - mode 00 uses last receive antenna, the one with last valid header.
// - mode 10 uses antenna B, select pin low.
// - mode 11 uses antenna A, select pin high.
// - preamble register gives eight-bit count loading the preamble counter.
// - preamble sent is two symbols longer than the programmed count.
// - scrambler bit 7 zero gates receive clock by enable; one runs free.
`timescale 1ns/1ps
module apc_antenna_preamble_config
	import apc_pkg::*;
#(
	parameter int DWELL_CYCLES = APC_DWELL_CYCLES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control port, register side
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// modem pins
	input wire logic receive_enable_input_i,
	input wire logic transmit_power_enable_i,
	output logic antenna_select_pin_o,
	// modem core status
	input wire logic acquiring_i,
	input wire logic valid_header_i,
	input wire logic header_antenna_i,
	input wire logic multipath_pick_valid_i,
	input wire logic multipath_pick_ant_i,
	input wire logic preamble_symbol_i,
	// modem core controls
	output apc_cfg_t cfg_o,
	output logic [8:0] preamble_total_o,
	output logic preamble_busy_o,
	output logic rx_clock_enable_o
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] rxe_sync_q;
	logic [1:0] txe_sync_q;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rxe_sync_q <= 2'b00;
			txe_sync_q <= 2'b00;
		end
		else
		begin
			rxe_sync_q <= {rxe_sync_q[0], receive_enable_input_i};
			txe_sync_q <= {txe_sync_q[0], transmit_power_enable_i};
		end
	end
	logic rx_en;
	logic tx_en;
	assign rx_en = rxe_sync_q[1];
	assign tx_en = txe_sync_q[1];

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] ant_ctrl_q;
	logic [7:0] ant_ctrl_d;
	logic [7:0] preamble_q;
	logic [7:0] preamble_d;
	logic [7:0] scrambler_q;
	logic [7:0] scrambler_d;
	// address decode for writes; reserved bit kept at zero
	always_comb
	begin
		ant_ctrl_d = ant_ctrl_q;
		preamble_d = preamble_q;
		scrambler_d = scrambler_q;
		if (reg_wr_i && reg_addr_i == APC_ADDR_ANT_CTRL)
		begin
			ant_ctrl_d = reg_wdata_i;
			ant_ctrl_d[APC_BIT_RSVD] = 1'b0;
		end
		else if (reg_wr_i && reg_addr_i == APC_ADDR_PREAMBLE)
		begin
			preamble_d = reg_wdata_i;
		end
		else if (reg_wr_i && reg_addr_i == APC_ADDR_SCRAMBLER)
		begin
			scrambler_d = reg_wdata_i;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ant_ctrl_q <= APC_RST_ANT_CTRL;
			preamble_q <= APC_RST_PREAMBLE;
			scrambler_q <= APC_RST_SCRAMBLER;
		end
		else
		begin
			ant_ctrl_q <= ant_ctrl_d;
			preamble_q <= preamble_d;
			scrambler_q <= scrambler_d;
		end
	end
	// read mux, registered; unmapped addresses read zero
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	always_comb
	begin
		if (reg_addr_i == APC_ADDR_ANT_CTRL)
		begin
			rdata_d = ant_ctrl_q;
		end
		else if (reg_addr_i == APC_ADDR_PREAMBLE)
		begin
			rdata_d = preamble_q;
		end
		else if (reg_addr_i == APC_ADDR_SCRAMBLER)
		begin
			rdata_d = scrambler_q;
		end
		else
		begin
			rdata_d = 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// acquisition option latch
	// ---------------------------------------------------------------
	// timing adjust bit is only sampled while receive is idle, so a change
	// mid-receive cannot disturb an acquisition in progress
	logic adc_adj_q;
	logic adc_adj_d;
	always_comb
	begin
		adc_adj_d = adc_adj_q;
		if (!rx_en)
		begin
			adc_adj_d = ant_ctrl_q[APC_BIT_ADC_ADJ];
		end
	end

	// ---------------------------------------------------------------
	// antenna selection
	// ---------------------------------------------------------------
	apc_ant_mode_t mode;
	assign mode = apc_ant_mode_t'(ant_ctrl_q[1:0]);
	logic diversity;
	assign diversity = ant_ctrl_q[APC_BIT_DIVERSITY];
	logic dwell_tick;
	apc_dwell_timer #(
		.CYCLES(DWELL_CYCLES)
	) u_dwell (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.enable_i(acquiring_i & diversity & rx_en),
		.tick_o(dwell_tick)
	);
	// start antenna for a mode: 1 is antenna A, 0 is antenna B
	function automatic logic start_ant(input apc_ant_mode_t m, input logic last_ant);
		logic r;
		r = last_ant;
		case (m)
			APC_MODE_A: r = 1'b1;
			APC_MODE_B: r = 1'b0;
			default: r = last_ant;
		endcase
		return r;
	endfunction : start_ant

	logic last_ant_q;
	logic last_ant_d;
	logic ant_q;
	logic ant_d;
	logic acq_q;
	logic acq_d;
	// header antenna remembered for mode 00; multipath pick overrides when enabled
	always_comb
	begin
		last_ant_d = last_ant_q;
		ant_d = ant_q;
		acq_d = acquiring_i;
		if (valid_header_i)
		begin
			last_ant_d = header_antenna_i;
		end
		if (tx_en)
		begin
			ant_d = ant_q;
		end
		else if (acquiring_i && !acq_q)
		begin
			ant_d = start_ant(mode, last_ant_q);
		end
		else if (acquiring_i && diversity && dwell_tick)
		begin
			ant_d = ~ant_q;
		end
		else if (acquiring_i && ant_ctrl_q[APC_BIT_MULTIPATH] && multipath_pick_valid_i)
		begin
			ant_d = multipath_pick_ant_i;
		end
		else if (!acquiring_i && !rx_en)
		begin
			ant_d = start_ant(mode, last_ant_q);
		end
	end

	// ---------------------------------------------------------------
	// preamble length
	// ---------------------------------------------------------------
	// counter loads on transmit start, counts symbols including ramp-up
	logic [8:0] pre_cnt_q;
	logic [8:0] pre_cnt_d;
	logic txe_prev_q;
	logic [8:0] pre_total;
	assign pre_total = {1'b0, preamble_q} + {1'b0, APC_PA_RAMP_SYMBOLS};
	always_comb
	begin
		pre_cnt_d = pre_cnt_q;
		if (!tx_en)
		begin
			pre_cnt_d = 9'h000;
		end
		else if (!txe_prev_q)
		begin
			pre_cnt_d = pre_total;
		end
		else if (preamble_symbol_i && pre_cnt_q != 9'h000)
		begin
			pre_cnt_d = pre_cnt_q - 9'h001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			adc_adj_q <= 1'b0;
			last_ant_q <= 1'b1;
			ant_q <= 1'b1;
			acq_q <= 1'b0;
			pre_cnt_q <= 9'h000;
			txe_prev_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else
		begin
			adc_adj_q <= adc_adj_d;
			last_ant_q <= last_ant_d;
			ant_q <= ant_d;
			acq_q <= acq_d;
			pre_cnt_q <= pre_cnt_d;
			txe_prev_q <= tx_en;
			rdata_q <= rdata_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o = rdata_q;
	assign antenna_select_pin_o = ant_q;
	assign preamble_total_o = pre_cnt_q;
	assign preamble_busy_o = (pre_cnt_q != 9'h000);
	assign cfg_o.cover_code_sel = ant_ctrl_q[APC_BIT_COVER_SEL];
	assign cfg_o.adc_timing_adjust = adc_adj_q;
	assign cfg_o.delayed_bit_sync = ant_ctrl_q[APC_BIT_DELAY_SYNC];
	assign cfg_o.multipath_select = ant_ctrl_q[APC_BIT_MULTIPATH];
	assign cfg_o.diversity_on = diversity;
	assign cfg_o.rx_clock_free = scrambler_q[APC_BIT_RXCLK_FREE];
	// free-running option or gated by synchronised receive enable
	assign rx_clock_enable_o = scrambler_q[APC_BIT_RXCLK_FREE] | rx_en;
endmodule : apc_antenna_preamble_config

// ### tb/apc_asserts.sv
// Purpose: port checks for the antenna / preamble configuration block
// Assumes: shadow registers follow host writes exactly
// Notes: pin checks wait for the synchronised pin inputs to settle
`timescale 1ns/1ps
module apc_asserts
	import apc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// pins and core side
	input wire logic receive_enable_input_i,
	input wire logic transmit_power_enable_i,
	input wire logic antenna_select_pin_o,
	input wire logic acquiring_i,
	input wire apc_cfg_t cfg_o,
	input wire logic [8:0] preamble_total_o,
	input wire logic rx_clock_enable_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic [7:0] ctl_q, ctl_d, pre_q, pre_d;
	// shadows let the checks know the programmed mode and count
	always_comb
	begin
		ctl_d = ctl_q;
		pre_d = pre_q;
		if (reg_wr_i && reg_addr_i == APC_ADDR_ANT_CTRL) ctl_d = reg_wdata_i;
		if (reg_wr_i && reg_addr_i == APC_ADDR_PREAMBLE) pre_d = reg_wdata_i;
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i) {ctl_q, pre_q} <= 16'h0000;
		else {ctl_q, pre_q} <= {ctl_d, pre_d};
	// ---------------------------------------------------------------
	// sequences and properties
	// ---------------------------------------------------------------
	sequence s_ctl_wr;
		reg_wr_i && reg_addr_i == APC_ADDR_ANT_CTRL;
	endsequence
	// four idle cycles cover the two-flop synchronisers
	sequence s_idle;
		(!acquiring_i && !transmit_power_enable_i && !receive_enable_input_i)[*4];
	endsequence
	sequence s_tx_on;
		$rose(transmit_power_enable_i) ##1 transmit_power_enable_i[*2];
	endsequence
	AST_COVER_SEL: assert property (s_ctl_wr |=> cfg_o.cover_code_sel == ctl_q[7])
		else $error("cover select bit wrong");
	AST_DELAY_SYNC: assert property (s_ctl_wr |=> cfg_o.delayed_bit_sync == ctl_q[4])
		else $error("bit sync delay wrong");
	AST_MULTIPATH: assert property (s_ctl_wr |=> cfg_o.multipath_select == ctl_q[3])
		else $error("multipath select wrong");
	AST_DIVERSITY: assert property (s_ctl_wr |=> cfg_o.diversity_on == ctl_q[2])
		else $error("diversity bit wrong");
	AST_READBACK: assert property (s_ctl_wr ##1 (reg_addr_i == APC_ADDR_ANT_CTRL && !reg_wr_i)
		|=> reg_rdata_o == (ctl_q & 8'hBF))
		else $error("antenna control readback wrong");
	AST_PRE_LOAD: assert property (s_tx_on |=> preamble_total_o == {1'b0, pre_q} + 9'h002)
		else $error("preamble total not count plus two");
	// gated half follows the receive enable pin two synchroniser stages late
	AST_RXCLK_FREE: assert property (rx_clock_enable_o == (cfg_o.rx_clock_free || $past(receive_enable_input_i, 2)))
		else $error("receive clock gated while free running");
	AST_PIN_B: assert property (s_idle ##0 (ctl_q[1:0] == 2'b10 && $stable(ctl_q)) |-> !antenna_select_pin_o)
		else $error("pin not low for antenna B");
	AST_PIN_A: assert property (s_idle ##0 (ctl_q[1:0] == 2'b11 && $stable(ctl_q)) |-> antenna_select_pin_o)
		else $error("pin not high for antenna A");
	AST_START_ANT: assert property ($rose(acquiring_i) && ctl_q[1:0] == 2'b11 |=> antenna_select_pin_o)
		else $error("acquisition not started on mode antenna");
endmodule : apc_asserts

// ### tb/apc_host_model.sv
// Purpose: host controller driving the byte control port
// Assumes: one write strobe per access, read data one cycle after address
// Notes: drives only on falling edges so the block samples settled values
`timescale 1ns/1ps
module apc_host_model
	import apc_pkg::*;
(
	input wire logic clk_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	initial
	begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
	end
	// the reserved bit is always written as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		// callers never ask for antenna mode 01, whose behaviour is undefined
		reg_addr_o = a;
		reg_wdata_o = (a == APC_ADDR_ANT_CTRL) ? (d & 8'hBF) : d;
		reg_wr_o = 1'b1;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~reg_wdata_o;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		@(negedge clk_i);
		d = reg_rdata_i;
	endtask : rd
endmodule : apc_host_model

// ### tb/test_antenna_preamble_config.sv
// Purpose: directed bench for the antenna / preamble configuration block
// Assumes: dwell shortened to 8 cycles, mode 01 never programmed
// Notes: settle waits cover the two-flop pin synchronisers
`timescale 1ns/1ps
module test_antenna_preamble_config;
	import apc_pkg::*;
	logic clk_i, rst_n_i, reg_wr_i, rx, tx, acq, vh, ha, mpv, mpa, sym, pin, busy, rxce;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [8:0] total;
	apc_cfg_t cfg;
	int n_errors = 0;
	int check_count = 0;
	apc_antenna_preamble_config #(.DWELL_CYCLES(8)) i_apc_antenna_preamble_config (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .receive_enable_input_i(rx), .transmit_power_enable_i(tx),
		.antenna_select_pin_o(pin), .acquiring_i(acq), .valid_header_i(vh), .header_antenna_i(ha),
		.multipath_pick_valid_i(mpv), .multipath_pick_ant_i(mpa), .preamble_symbol_i(sym), .cfg_o(cfg),
		.preamble_total_o(total), .preamble_busy_o(busy), .rx_clock_enable_o(rxce));
	apc_host_model i_apc_host_model (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
		.reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// single-level results get their own compare so nothing is padded on the way in
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic close_out();
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_apc_host_model.wr(a, d);
		cyc(3);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_apc_host_model.rd(a, d);
		chk({1'b0, d}, {1'b0, exp});
	endtask : rdchk
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		wr(APC_ADDR_ANT_CTRL, 8'h9B);
		chk({3'b000, cfg}, 9'h02C);
		rdchk(APC_ADDR_ANT_CTRL, 8'h9B);
		wr(8'h20, 8'h55);
		rdchk(8'h20, 8'h00);
		chk_bit(pin, 1'b1);
		wr(APC_ADDR_ANT_CTRL, 8'h02);
		chk_bit(pin, 1'b0);
		wr(APC_ADDR_SCRAMBLER, 8'h80);
		chk_bit(rxce, 1'b1);
		chk_bit(cfg.rx_clock_free, 1'b1);
		wr(APC_ADDR_SCRAMBLER, 8'h00);
		chk_bit(rxce, 1'b0);
		rx = 1'b1;
		cyc(4);
		chk_bit(rxce, 1'b1);
	endtask : t_regs
	// timing adjust must wait for the receive enable to drop
	task automatic t_adc();
		wr(APC_ADDR_ANT_CTRL, 8'h23);
		chk_bit(cfg.adc_timing_adjust, 1'b0);
		rx = 1'b0;
		cyc(4);
		chk_bit(cfg.adc_timing_adjust, 1'b1);
	endtask : t_adc
	task automatic t_pre(input logic [7:0] n);
		wr(APC_ADDR_PREAMBLE, n);
		tx = 1'b1;
		cyc(5);
		chk(total, {1'b0, n} + 9'h002);
		sym = 1'b1;
		cyc(2);
		sym = 1'b0;
		cyc(1);
		chk(total, {1'b0, n});
		chk_bit(busy, 1'b1);
	endtask : t_pre
	// mode change while transmitting must not move the pin
	task automatic t_freeze();
		wr(APC_ADDR_ANT_CTRL, 8'h02);
		cyc(4);
		chk_bit(pin, 1'b1);
		tx = 1'b0;
		cyc(5);
		chk_bit(pin, 1'b0);
		chk_bit(busy, 1'b0);
	endtask : t_freeze
	task automatic t_div();
		wr(APC_ADDR_ANT_CTRL, 8'h07);
		rx = 1'b1;
		cyc(4);
		acq = 1'b1;
		cyc(3);
		chk_bit(pin, 1'b1);
		cyc(9);
		chk_bit(pin, 1'b0);
		cyc(8);
		chk_bit(pin, 1'b1);
		acq = 1'b0;
		rx = 1'b0;
	endtask : t_div
	task automatic t_last(input logic a);
		wr(APC_ADDR_ANT_CTRL, 8'h00);
		ha = a;
		vh = 1'b1;
		cyc(1);
		vh = 1'b0;
		acq = 1'b1;
		cyc(3);
		chk_bit(pin, a);
		acq = 1'b0;
	endtask : t_last
	task automatic t_mp();
		wr(APC_ADDR_ANT_CTRL, 8'h0B);
		acq = 1'b1;
		cyc(3);
		mpv = 1'b1;
		cyc(1);
		mpv = 1'b0;
		cyc(2);
		chk_bit(pin, 1'b0);
		acq = 1'b0;
	endtask : t_mp
	// ---------------------------------------------------------------
	// clock, watchdog and main sequence
	// ---------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (3000) @(posedge clk_i);
		n_errors++;
		close_out();
	end
	initial
	begin
		{rst_n_i, rx, tx, acq, vh, ha, mpv, mpa, sym} = 9'h000;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		t_regs();
		t_adc();
		t_pre(8'h80);
		t_freeze();
		t_pre(8'hFF);
		tx = 1'b0;
		t_div();
		t_last(1'b0);
		t_last(1'b1);
		t_mp();
		close_out();
	end
endmodule : test_antenna_preamble_config
bind apc_antenna_preamble_config apc_asserts i_apc_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.receive_enable_input_i(receive_enable_input_i), .transmit_power_enable_i(transmit_power_enable_i),
	.antenna_select_pin_o(antenna_select_pin_o), .acquiring_i(acquiring_i), .cfg_o(cfg_o),
	.preamble_total_o(preamble_total_o), .rx_clock_enable_o(rx_clock_enable_o));
